/* logic/basic_interval_timer_defs.svh */
// Register offsets, field positions and reset values of the interval timer
`ifndef BASIC_INTERVAL_TIMER_DEFS_SVH
`define BASIC_INTERVAL_TIMER_DEFS_SVH

`define TMR_COUNT_OFS 5'h00
`define TMR_RELOAD_OFS 5'h04
`define TMR_STATUS_OFS 5'h08
`define TMR_IRQEN_OFS 5'h0c
`define TMR_CONTROL_OFS 5'h10

`define CTL_ENABLE_BIT 0
`define CTL_UP_BIT 2
`define CTL_AUTO_BIT 3
`define CTL_SOFTRST_BIT 4
`define CTL_START_BIT 5
`define CTL_SPARE_BIT 6
`define CTL_HALT_BIT 7
`define CTL_PRESCALE_LSB 16
`define CTL_PRESCALE_MSB 31

`define TMR_RESET_VALUE 32'h0000_0000
`define TMR_SYS_CLK_MHZ 48

`endif

/* logic/basic_interval_timer_pkg.sv */
// Types shared by the interval timer
package basic_interval_timer_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } run_state_t;
endpackage

/* logic/basic_interval_timer.sv */
// Basic interval timer with prescaler, APB register slave
// Function
// - Width parameter selects 16 or 32 bit counter and preload.
// - Counter runs on system clock, slowed only by prescaler enables.
// - Internal reset is system reset OR soft reset, clears everything.
// - Interrupt output is limit status gated by its enable.
// - Active only when enabled, started and not halted.
// - One-shot mode stops at limit with a level status.
// - Continuous mode reloads from preload and pulses status one cycle.
// - Counter is firmware read/write, hardware updated, resets to zero.
// - Counter reads come from a consistent snapshot.
// - In 16-bit build upper counter bits read zero, ignore writes.
// - Restart leaves the counter as it is; preload is loaded only at limit in continuous mode; preload sized like counter.
// - Status bit 0 cleared by write; pulse in continuous, level else.
// - Enable bit 0 gates status to interrupt; resets to zero.
// - Prescale bits 31:16 give one enable per value plus one clocks.
// - Halt bit 7 stops counting, resets divider, resumes afterwards.
// - Start bit 5 clears itself at one-shot end, stays in continuous.
// - Setting start resets divider, starts counting, clears status.
// - Clearing start disables divider and stops counter.
// - Bit 2 selects up or down; one-shot holds at all ones or zero.
// - Bit 3 selects continuous reload or done state.
// - Enable bit 0 allows operation; zero gates the block.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "basic_interval_timer_defs.svh"

module basic_interval_timer #(
    parameter int WIDTH = 32
) (
    input wire logic pclk, // System clock, 48 MHz nominal
    input wire logic presetn, // System reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    output logic timer_irq, // Interrupt request, level in one-shot mode, one-cycle pulse in continuous mode
    output logic timer_active // High while counting, low when it may sleep
);
    // ==========================================================
    // Bus decode
    logic soft_reset;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] reload;
    logic [31:0] snapshot;
    logic [31:0] control;
    logic status;
    logic irq_en;
    logic [15:0] div_count;
    logic tick;
    logic at_limit;
    basic_interval_timer_pkg::run_state_t state;

    wire logic access = psel && penable && !pready;
    wire logic setup = psel && !penable;
    wire logic wr = access && pwrite;
    wire logic mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0)
        && (paddr[4:0] <= `TMR_CONTROL_OFS);
    wire logic wr_count = wr && mapped && paddr[4:0] == `TMR_COUNT_OFS;
    wire logic wr_reload = wr && mapped && paddr[4:0] == `TMR_RELOAD_OFS;
    wire logic wr_status = wr && mapped && paddr[4:0] == `TMR_STATUS_OFS;
    wire logic wr_irqen = wr && mapped && paddr[4:0] == `TMR_IRQEN_OFS;
    wire logic wr_control = wr && mapped && paddr[4:0] == `TMR_CONTROL_OFS;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[WIDTH-1:0] = v;
        return r;
    endfunction

    wire logic [31:0] next_control = merge(control, pwdata, pstrb);
    wire logic start_rise = wr_control && next_control[`CTL_START_BIT]
        && !control[`CTL_START_BIT];
    wire logic enabled = control[`CTL_ENABLE_BIT];
    wire logic running = enabled && control[`CTL_START_BIT]
        && !control[`CTL_HALT_BIT];
    wire logic count_up = control[`CTL_UP_BIT];
    wire logic auto_restart = control[`CTL_AUTO_BIT];

    // Combined internal reset; soft reset is a registered pulse so it is glitch free
    wire logic timer_rst_n = presetn && !soft_reset;

    // ==========================================================
    // Soft reset request
    // Raised at the edge where the master takes pready, so the write is answered
    // before the reset clears the bus outputs; firing earlier would swallow pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= pready && psel && penable && pwrite && mapped
                && paddr[4:0] == `TMR_CONTROL_OFS && pstrb[0]
                && pwdata[`CTL_SOFTRST_BIT];
        end
    end

    // ==========================================================
    // APB handshake: one wait cycle, answer in the second access cycle
    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            if (access && !pwrite && mapped) begin
                case (paddr[4:0])
                    `TMR_COUNT_OFS: prdata <= snapshot;
                    `TMR_RELOAD_OFS: prdata <= widen(reload);
                    `TMR_STATUS_OFS: prdata <= {31'h0, status};
                    `TMR_IRQEN_OFS: prdata <= {31'h0, irq_en};
                    `TMR_CONTROL_OFS: prdata <= control;
                    default: prdata <= 32'h0000_0000;
                endcase
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Snapshot taken at setup so every byte of one read comes from one value
    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            snapshot <= `TMR_RESET_VALUE;
        end else if (setup && paddr[4:0] == `TMR_COUNT_OFS) begin
            snapshot <= widen(count);
        end
    end

    // ==========================================================
    // Control register
    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            control <= `TMR_RESET_VALUE;
        end else if (wr_control) begin
            control <= next_control & 32'hffff_00ed;
        end else if (running && tick && at_limit && !auto_restart) begin
            control[`CTL_START_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            irq_en <= 1'b0;
        end else if (wr_irqen && pstrb[0]) begin
            irq_en <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            reload <= WIDTH'(0);
        end else if (wr_reload) begin
            reload <= WIDTH'(merge(widen(reload), pwdata, pstrb));
        end
    end

    // ==========================================================
    // Prescaler: halted, stopped or restarted resets the divider
    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            div_count <= 16'h0000;
        end else if (!running || start_rise) begin
            div_count <= 16'h0000;
        end else if (div_count >= control[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB]) begin
            div_count <= 16'h0000;
        end else begin
            div_count <= div_count + 16'h0001;
        end
    end

    assign tick = running && !start_rise
        && div_count >= control[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB];
    assign at_limit = count_up ? (count == {WIDTH{1'b1}}) : (count == WIDTH'(0));

    // ==========================================================
    // Counter and run state
    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            count <= WIDTH'(0);
        end else if (wr_count) begin
            count <= WIDTH'(merge(widen(count), pwdata, pstrb));
        end else if (tick) begin
            if (at_limit) begin
                if (auto_restart) begin
                    count <= reload;
                end
            end else if (count_up) begin
                count <= count + WIDTH'(1);
            end else begin
                count <= count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            state <= basic_interval_timer_pkg::ST_IDLE;
        end else begin
            case (state)
                basic_interval_timer_pkg::ST_IDLE:
                    if (running) begin
                        state <= basic_interval_timer_pkg::ST_RUN;
                    end
                basic_interval_timer_pkg::ST_RUN:
                    if (tick && at_limit && !auto_restart) begin
                        state <= basic_interval_timer_pkg::ST_DONE;
                    end else if (!control[`CTL_START_BIT]) begin
                        state <= basic_interval_timer_pkg::ST_IDLE;
                    end
                basic_interval_timer_pkg::ST_DONE:
                    if (start_rise) begin
                        state <= basic_interval_timer_pkg::ST_RUN;
                    end
                default: state <= basic_interval_timer_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Limit status: hardware set wins over software clear
    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            status <= 1'b0;
        end else if (tick && at_limit) begin
            status <= 1'b1;
        end else if (start_rise) begin
            status <= 1'b0;
        end else if (auto_restart) begin
            status <= 1'b0;
        end else if (wr_status && pstrb[0] && pwdata[0]) begin
            status <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge timer_rst_n) begin
        if (!timer_rst_n) begin
            timer_irq <= 1'b0;
            timer_active <= 1'b0;
        end else begin
            timer_irq <= status && irq_en;
            timer_active <= running;
        end
    end
endmodule

/* tb/basic_interval_timer_assertions.sv */
// Port-level checks of the interval timer register slave
`timescale 1ns/10ps
module basic_interval_timer_assertions (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB strobes
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic timer_irq, // Interrupt
    input wire logic timer_active // Activity
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Access phase still waiting for its answer
    wire logic req = psel && penable && !pready;

    pulse_ready_a: assert property (pready |=> !pready)
        else $error("pready stayed high");
    ready_after_wait_a: assert property (req |=> pready)
        else $error("no answer after one wait state");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    setup_no_ready_a: assert property (psel && !penable |-> !pready)
        else $error("pready in setup cycle");
    err_only_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero while idle");
    unmapped_err_a: assert property (req && paddr > 32'h10 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_no_err_a: assert property (req && paddr <= 32'h10 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");

    cover property (req && pwrite);
    cover property (req && !pwrite);
    cover property (pslverr);
    cover property (timer_irq);
endmodule

bind basic_interval_timer basic_interval_timer_assertions i_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .timer_irq,
    .timer_active);

/* tb/basic_interval_timer_tb.sv */
// Self-checking bench of the interval timer
`timescale 1ns/10ps
module basic_interval_timer_tb;
    typedef struct {logic [31:0] a, d, x;} row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, r, c2;
    logic pready, pslverr, timer_irq, timer_active, e;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    // Reserved control bits 15:8 must read back zero
    row_t rows[5] = '{'{32'h0, 32'h1234_5678, 32'h1234_5678}, '{32'h4, 32'hdead_beef,
        32'hdead_beef}, '{32'hc, 32'hffff_ffff, 32'h1}, '{32'h8, 32'h1, 32'h0},
        '{32'h10, 32'h0003_ff4c, 32'h0003_004c}};

    always #2 pclk = ~pclk;

    basic_interval_timer #(.WIDTH(32)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .timer_irq, .timer_active);

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", s, x, g);
        end
    endtask

    // ==========================================
    // APB master: hold the request until pready is sampled
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("reset value", 32'h0, r);
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk("readback", rows[i].x, r);
        end
        // ==========================================
        // One-shot down count to zero at full speed
        apb(1'b1, 32'h0, 32'h3);
        apb(1'b1, 32'h10, 32'h21);
        repeat (10) @(posedge pclk);
        #1;
        chk("irq", 32'h1, {31'h0, timer_irq});
        chk("active", 32'h0, {31'h0, timer_active});
        apb(1'b0, 32'h10, 32'h0);
        chk("start cleared", 32'h1, r);
        apb(1'b0, 32'h0, 32'h0);
        chk("down limit", 32'h0, r);
        apb(1'b0, 32'h8, 32'h0);
        chk("level status", 32'h1, r);
        apb(1'b1, 32'h8, 32'h1);
        apb(1'b0, 32'h8, 32'h0);
        chk("status cleared", 32'h0, r);
        // ==========================================
        // Prescale 4 up count, halted mid-run
        apb(1'b1, 32'h0, 32'h0);
        apb(1'b1, 32'h10, 32'h0004_0025);
        repeat (30) @(posedge pclk);
        apb(1'b1, 32'h10, 32'h0004_00a5);
        apb(1'b0, 32'h0, 32'h0);
        c2 = r;
        repeat (20) @(posedge pclk);
        #1;
        chk("halted idle", 32'h0, {31'h0, timer_active});
        apb(1'b0, 32'h0, 32'h0);
        chk("halt holds", c2, r);
        apb(1'b1, 32'h10, 32'h0004_0025);
        repeat (20) @(posedge pclk);
        #1;
        chk("running", 32'h1, {31'h0, timer_active});
        apb(1'b0, 32'h0, 32'h0);
        chk("tick rate", 32'h1, {31'h0, (r - c2) inside {[3:5]}});
        // ==========================================
        // Continuous up count wraps to the reload value
        apb(1'b1, 32'h10, 32'h0);
        apb(1'b1, 32'h4, 32'hffff_fff0);
        apb(1'b1, 32'h0, 32'hffff_fff0);
        apb(1'b1, 32'h10, 32'h2d);
        for (int i = 0; i < 60 && timer_irq !== 1'b1; i++) @(posedge pclk);
        chk("pulse", 32'h1, {31'h0, timer_irq});
        @(posedge pclk);
        chk("pulse ends", 32'h0, {31'h0, timer_irq});
        apb(1'b0, 32'h10, 32'h0);
        chk("start stays", 32'h2d, r);
        apb(1'b0, 32'h0, 32'h0);
        chk("reloaded", 32'h1, {31'h0, r >= 32'hffff_fff0});
        apb(1'b0, 32'h14, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        // ==========================================
        // Soft reset clears the reload and control registers
        apb(1'b1, 32'h10, 32'h10);
        repeat (2) @(posedge pclk);
        apb(1'b0, 32'h4, 32'h0);
        chk("soft reset", 32'h0, r);
        apb(1'b0, 32'h10, 32'h0);
        chk("control cleared", 32'h0, r);
        tally_and_finish();
    end
endmodule
